// >>> logic/lste_pkg.sv
// Constants and types for the local store transfer engine
package lste_pkg;
	localparam int FN_W = 5;
	localparam int SEL_W = 3;
	localparam int IDX_W = 5;
	// Entry-point codes; load-read and load-address also have alias codes
	localparam logic [FN_W-1:0] FN_READ = 5'h00;
	localparam logic [FN_W-1:0] FN_READ_INC = 5'h01;
	localparam logic [FN_W-1:0] FN_LOAD_READ = 5'h02;
	localparam logic [FN_W-1:0] FN_LOAD_READ_ALT = 5'h03;
	localparam logic [FN_W-1:0] FN_WRITE = 5'h04;
	localparam logic [FN_W-1:0] FN_WRITE_INC = 5'h05;
	localparam logic [FN_W-1:0] FN_LOAD_WRITE = 5'h06;
	localparam logic [FN_W-1:0] FN_LOAD_WRITE_INC = 5'h07;
	localparam logic [FN_W-1:0] FN_INC_READ = 5'h08;
	localparam logic [FN_W-1:0] FN_LOAD_ADDR = 5'h09;
	localparam logic [FN_W-1:0] FN_SET_LOAD = 5'h0A;
	localparam logic [FN_W-1:0] FN_SET_STORE = 5'h0B;
	localparam logic [FN_W-1:0] FN_LOAD_READ_TWO = 5'h0C;
	localparam logic [FN_W-1:0] FN_INC_READ_TWO = 5'h0D;
	localparam logic [FN_W-1:0] FN_LOAD_WRITE_TWO = 5'h0E;
	localparam logic [FN_W-1:0] FN_INC_WRITE_TWO = 5'h0F;
	localparam logic [FN_W-1:0] FN_READ_IND = 5'h10;
	localparam logic [FN_W-1:0] FN_WRITE_IND = 5'h11;
	// Block codes: bit 0 set means load from local store
	localparam logic [FN_W-1:0] FN_BLK_GR = 5'h12;
	localparam logic [FN_W-1:0] FN_BLK_FP = 5'h14;
	localparam logic [FN_W-1:0] FN_BLK_CSP = 5'h16;
	localparam logic [FN_W-1:0] FN_BLK_WORK = 5'h18;
	localparam logic [FN_W-1:0] FN_BLK_ASP = 5'h1A;
	localparam logic [FN_W-1:0] FN_BLK_BSP = 5'h1C;
	localparam logic [FN_W-1:0] FN_BLK_ALLCSP = 5'h1E;
	// Processor state targets
	localparam logic [SEL_W-1:0] SEL_GR = 3'h0;
	localparam logic [SEL_W-1:0] SEL_FP = 3'h1;
	localparam logic [SEL_W-1:0] SEL_CSP = 3'h2;
	localparam logic [SEL_W-1:0] SEL_WORK = 3'h3;
	localparam logic [SEL_W-1:0] SEL_ASP = 3'h4;
	localparam logic [SEL_W-1:0] SEL_BSP = 3'h5;
	// Last index of each block
	localparam logic [IDX_W-1:0] LAST_GR = 5'h07;
	localparam logic [IDX_W-1:0] LAST_FP = 5'h17;
	localparam logic [IDX_W-1:0] LAST_CSP = 5'h0B;
	localparam logic [IDX_W-1:0] LAST_ALLCSP = 5'h0F;
	localparam logic [IDX_W-1:0] LAST_WORK = 5'h07;
	localparam logic [IDX_W-1:0] LAST_SP = 5'h1F;
	typedef enum logic [1:0] {
		LSTE_IDLE = 2'b00,
		LSTE_ITEM = 2'b01,
		LSTE_BLK = 2'b10,
		LSTE_RET = 2'b11
	} lste_state_t;
endpackage

// >>> logic/lste_engine.sv
// Local store transfer engine: single, pair, indirect and block moves
`timescale 1ns/100ps
module lste_engine #(
	parameter int DW = 16,
	parameter int LS_AW = 9
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Caller side
	input wire logic ep_load_i,
	input wire logic [lste_pkg::FN_W-1:0] ep_code_i,
	input wire logic [LS_AW-1:0] d_reg_i,
	input wire logic [DW-1:0] md_i,
	input wire logic [DW-1:0] md2_i,
	input wire logic [DW-1:0] work_reg_a0_i,
	output logic busy_o,
	output logic return_o,
	output logic [DW-1:0] md_o,
	output logic [DW-1:0] md2_o,
	output logic [LS_AW-1:0] local_store_address_o,
	// Processor state port
	output logic [lste_pkg::SEL_W-1:0] st_sel_o,
	output logic [lste_pkg::IDX_W-1:0] st_idx_o,
	output logic st_re_o,
	output logic st_we_o,
	output logic [DW-1:0] st_wdata_o,
	input wire logic [DW-1:0] st_rdata_i
);
	import lste_pkg::*;

	if (DW < LS_AW || LS_AW < 6) begin : g_bad_params
		$error("lste_engine: DW must cover LS_AW and LS_AW must be at least 6");
	end

	logic [DW-1:0] mem [0:(1<<LS_AW)-1];
	lste_state_t state;
	lste_state_t next_state;
	logic d_valid, d_ld, d_pre, d_post, d_rd, d_wr, d_two, d_ind, d_blk, d_bload;
	logic [SEL_W-1:0] d_sel;
	logic [IDX_W-1:0] d_last;
	logic r_post, r_rd, r_wr, r_two, r_blk, r_bload, second, phase;
	logic [FN_W-1:0] r_code;
	logic [SEL_W-1:0] r_sel;
	logic [IDX_W-1:0] r_last, idx;
	logic [LS_AW-1:0] laddr, start_addr, next_laddr;
	logic [DW-1:0] wdat, wdat2, xfer;
	logic accept, blk_done, item_done;
	logic r_ind_wr;

	// Function decode from the entry-point code
	always_comb begin
		{d_valid, d_ld, d_pre, d_post, d_rd, d_wr, d_two, d_ind, d_blk} = '0;
		d_bload = ep_code_i[0];
		d_sel = SEL_GR;
		d_last = LAST_GR;
		d_valid = 1'b1;
		case (ep_code_i)
			FN_READ: d_rd = 1'b1;
			FN_READ_INC: {d_rd, d_post} = 2'b11;
			FN_LOAD_READ, FN_LOAD_READ_ALT, FN_SET_LOAD: {d_ld, d_rd} = 2'b11;
			FN_WRITE: d_wr = 1'b1;
			FN_WRITE_INC: {d_wr, d_post} = 2'b11;
			FN_LOAD_WRITE: {d_ld, d_wr} = 2'b11;
			FN_LOAD_WRITE_INC: {d_ld, d_wr, d_post} = 3'b111;
			FN_INC_READ: {d_pre, d_rd} = 2'b11;
			FN_LOAD_ADDR, FN_SET_STORE: d_ld = 1'b1;
			FN_LOAD_READ_TWO: {d_ld, d_rd, d_two} = 3'b111;
			FN_INC_READ_TWO: {d_pre, d_rd, d_two} = 3'b111;
			FN_LOAD_WRITE_TWO: {d_ld, d_wr, d_two} = 3'b111;
			FN_INC_WRITE_TWO: {d_pre, d_wr, d_two} = 3'b111;
			FN_READ_IND: {d_ind, d_rd} = 2'b11;
			FN_WRITE_IND: {d_ind, d_wr} = 2'b11;
			default: begin
				// Block codes; unknown codes start nothing
				d_blk = 1'b1;
				d_ld = 1'b1;
				case ({ep_code_i[FN_W-1:1], 1'b0})
					FN_BLK_GR: d_sel = SEL_GR;
					FN_BLK_FP: begin
						d_sel = SEL_FP;
						d_last = LAST_FP;
					end
					FN_BLK_CSP: begin
						d_sel = SEL_CSP;
						d_last = LAST_CSP;
					end
					FN_BLK_WORK: begin
						d_sel = SEL_WORK;
						d_last = LAST_WORK;
					end
					FN_BLK_ASP: begin
						d_sel = SEL_ASP;
						d_last = LAST_SP;
					end
					FN_BLK_BSP: begin
						d_sel = SEL_BSP;
						d_last = LAST_SP;
					end
					FN_BLK_ALLCSP: begin
						d_sel = SEL_CSP;
						d_last = LAST_ALLCSP;
					end
					default: d_valid = 1'b0;
				endcase
			end
		endcase
	end

	// Entry loads while busy are dropped, not queued
	assign accept = (state == LSTE_IDLE) && ep_load_i && d_valid;
	assign item_done = !r_two || second;
	assign blk_done = phase && (idx == r_last);

	// Starting address; blocks take D, which holds address minus one
	always_comb begin
		if (d_ind && d_rd)
			start_addr = md_i[LS_AW-1:0];
		else if (d_ind)
			start_addr = work_reg_a0_i[LS_AW-1:0];
		else if (d_ld)
			start_addr = d_reg_i;
		else if (d_pre)
			start_addr = laddr + 1'b1;
		else
			start_addr = laddr;
	end

	// Local store address register, also mirrored on the output port
	always_comb begin
		next_laddr = laddr;
		if (accept)
			next_laddr = start_addr;
		else if (state == LSTE_ITEM && (!item_done || r_post))
			next_laddr = laddr + 1'b1;
		else if (state == LSTE_BLK && !phase)
			next_laddr = laddr + 1'b1;
	end

	always_comb begin
		next_state = state;
		case (state)
			LSTE_IDLE: if (accept) next_state = d_blk ? LSTE_BLK : LSTE_ITEM;
			LSTE_ITEM: if (item_done) next_state = LSTE_RET;
			LSTE_BLK: if (blk_done) next_state = LSTE_RET;
			LSTE_RET: next_state = LSTE_IDLE;
			default: next_state = LSTE_IDLE;
		endcase
	end

	// Sequencing and local store address
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state <= LSTE_IDLE;
			laddr <= '0;
			{r_post, r_rd, r_wr, r_two, r_blk, r_bload, second, phase} <= '0;
			r_code <= '0;
			r_sel <= SEL_GR;
			r_last <= '0;
			idx <= '0;
			wdat <= '0;
			wdat2 <= '0;
		end else begin
			state <= next_state;
			laddr <= next_laddr;
			if (accept) begin
				{r_post, r_rd, r_wr, r_two, r_blk, r_bload} <= {d_post, d_rd, d_wr, d_two, d_blk, d_bload};
				r_code <= ep_code_i;
				r_sel <= d_sel;
				r_last <= d_last;
				idx <= '0;
				second <= 1'b0;
				phase <= 1'b0;
				wdat <= md_i;
				wdat2 <= md2_i;
			end else if (state == LSTE_ITEM) begin
				second <= 1'b1;
			end else if (state == LSTE_BLK) begin
				phase <= !phase;
				if (phase)
					idx <= idx + 1'b1;
			end
		end
	end

	// Local store writes; single port, one writer
	always_ff @(posedge mclk_i) begin
		if (state == LSTE_ITEM && r_wr)
			mem[laddr] <= second ? wdat2 : wdat;
		else if (state == LSTE_BLK && phase && !r_bload)
			mem[laddr] <= st_rdata_i;
	end

	// Read data and block staging
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			md_o <= '0;
			md2_o <= '0;
			xfer <= '0;
		end else begin
			if (state == LSTE_ITEM && r_rd && !second)
				md_o <= mem[laddr];
			if (state == LSTE_ITEM && r_rd && second)
				md2_o <= mem[laddr];
			if (state == LSTE_BLK && !phase)
				xfer <= mem[laddr + 1'b1];
		end
	end

	// Caller handshake and processor state strobes
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
			return_o <= 1'b0;
			local_store_address_o <= '0;
			st_sel_o <= SEL_GR;
			st_idx_o <= '0;
			st_re_o <= 1'b0;
			st_we_o <= 1'b0;
			st_wdata_o <= '0;
		end else begin
			busy_o <= (next_state != LSTE_IDLE);
			return_o <= (next_state == LSTE_RET);
			// Tracks the register, so stale idle inputs never show here
			local_store_address_o <= next_laddr;
			st_re_o <= (state == LSTE_BLK) && !phase && !r_bload;
			st_we_o <= (state == LSTE_BLK) && phase && r_bload;
			st_sel_o <= r_sel;
			st_idx_o <= idx;
			st_wdata_o <= xfer;
		end
	end

	start_entry_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(busy_o) |-> $past(ep_load_i))
		else $error("engine started without an entry-point load");
	busy_refuse_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(busy_o && ep_load_i) |=> $stable(r_code))
		else $error("entry-point load taken while busy");
	return_end_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		return_o |=> (!return_o && !busy_o))
		else $error("return not followed by idle");
	single_len_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		($rose(busy_o) && !r_blk && !r_two) |-> !return_o ##1 return_o)
		else $error("single item did not return after one cycle");
	pair_len_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		($rose(busy_o) && r_two) |-> (!return_o [*2]) ##1 return_o)
		else $error("two-item transfer did not return after two cycles");
	load_addr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(busy_o) && $past(d_ld && !d_ind) |-> local_store_address_o == $past(d_reg_i))
		else $error("loaded address differs from D");
	ind_write_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		($rose(busy_o) && r_ind_wr) |-> local_store_address_o == $past(work_reg_a0_i[LS_AW-1:0]))
		else $error("indirect write address not taken from work_reg_a0");
	blk_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(st_re_o || st_we_o) |-> (st_idx_o <= r_last))
		else $error("block index beyond range");
	blk_finish_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(state == LSTE_BLK && blk_done) |=> return_o)
		else $error("block did not return after last word");

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			r_ind_wr <= 1'b0;
		else if (accept)
			r_ind_wr <= d_ind && d_wr;
	end
endmodule // lste_engine

// >>> verification/lste_proc_model.sv
// Processor state model facing the transfer engine
`timescale 1ns/100ps
module lste_proc_model #(
	parameter int DW = 16
) (
	// Clock
	input wire logic mclk_i,
	// State port
	input wire logic [lste_pkg::SEL_W-1:0] st_sel_i,
	input wire logic [lste_pkg::IDX_W-1:0] st_idx_i,
	input wire logic st_re_i,
	input wire logic st_we_i,
	input wire logic [DW-1:0] st_wdata_i,
	output logic [DW-1:0] st_rdata_o
);
	import lste_pkg::*;
	logic [DW-1:0] mem [8][32];
	logic [DW-1:0] junk = '0;
	int re_n = 0;
	int we_n = 0;
	initial begin
		for (int s = 0; s < 8; s++) begin
			for (int i = 0; i < 32; i++) begin
				mem[s][i] = DW'(32'hA000 + (s << 8) + i);
			end
		end
		// General register copies agree
		for (int i = 0; i < 8; i++) begin
			mem[SEL_BSP][i] = mem[SEL_ASP][i];
		end
		mem[SEL_CSP][15] = 16'h0001;
		mem[SEL_CSP][14] = 16'h0000;
		mem[SEL_CSP][12] = 16'h0002;
	end
	// Outside read strobes the bus toggles, so stale data cannot pass
	assign st_rdata_o = st_re_i ? mem[st_sel_i][st_idx_i] : junk;
	// Caller's constants-invalid flag: set while the constants are missing
	logic const_bad;
	assign const_bad = (mem[SEL_CSP][15] != DW'(16'h0001)) || (mem[SEL_CSP][14] != '0) || (mem[SEL_CSP][12] != DW'(16'h0002));
	always @(posedge mclk_i) begin
		junk <= ~junk;
		if (st_re_i) begin
			re_n <= re_n + 1;
		end
		if (st_we_i) begin
			mem[st_sel_i][st_idx_i] <= st_wdata_i;
			we_n <= we_n + 1;
		end
	end
endmodule // lste_proc_model

// >>> verification/tb_top.sv
// Self-checking bench for the local store transfer engine
`timescale 1ns/100ps
module tb_top;
	import lste_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ep_load_i;
	logic [FN_W-1:0] ep_code_i;
	logic [8:0] d_reg_i;
	logic [15:0] md_i;
	logic [15:0] md2_i;
	logic [15:0] work_reg_a0_i;
	logic busy_o, return_o, st_re_o, st_we_o;
	logic [15:0] md_o, md2_o, st_wdata_o, st_rdata_i;
	logic [8:0] local_store_address_o;
	logic [SEL_W-1:0] st_sel_o;
	logic [IDX_W-1:0] st_idx_o;
	int err_count = 0;
	int num_checks = 0;
	lste_engine #(.DW(16), .LS_AW(9)) lste_engine_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.ep_load_i(ep_load_i), .ep_code_i(ep_code_i), .d_reg_i(d_reg_i), .md_i(md_i), .md2_i(md2_i),
		.work_reg_a0_i(work_reg_a0_i), .busy_o(busy_o), .return_o(return_o), .md_o(md_o), .md2_o(md2_o),
		.local_store_address_o(local_store_address_o), .st_sel_o(st_sel_o), .st_idx_o(st_idx_o),
		.st_re_o(st_re_o), .st_we_o(st_we_o), .st_wdata_o(st_wdata_o), .st_rdata_i(st_rdata_i));
	lste_proc_model #(.DW(16)) lste_proc_model_i (.mclk_i(mclk_i), .st_sel_i(st_sel_o), .st_idx_i(st_idx_o),
		.st_re_i(st_re_o), .st_we_i(st_we_o), .st_wdata_i(st_wdata_o), .st_rdata_o(st_rdata_i));
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// One call; poke retries the load while busy, which must be ignored
	task automatic op(input logic [4:0] c, input logic [8:0] d = 9'h1FF, input logic [15:0] m = 16'h0,
		input logic [15:0] m2 = 16'h0, input logic [15:0] a0 = 16'h0, input int cyc = 2, input bit poke = 0);
		int k;
		k = 0;
		@(posedge mclk_i);
		ep_code_i <= c;
		d_reg_i <= d;
		md_i <= m;
		md2_i <= m2;
		work_reg_a0_i <= a0;
		ep_load_i <= 1'b1;
		// Caller only idles until control comes back
		do begin
			@(posedge mclk_i);
			k++;
			if (k < 3) ep_load_i <= (k == 1) && poke;
			#1;
			if (k == 1) check(busy_o, 1);
		end while (return_o !== 1'b1 && k < 200);
		check(k, cyc);
		check(k <= 300, 1);
		@(posedge mclk_i);
		#1;
		check(busy_o, 0);
	endtask
	task automatic t_reset();
		#1;
		check(busy_o, 0);
		check(return_o, 0);
		check(st_we_o, 0);
	endtask
	task automatic t_single();
		op(FN_LOAD_ADDR, 9'h005);
		check(local_store_address_o, 9'h005);
		op(FN_WRITE, , 16'h1111);
		op(FN_WRITE_INC, , 16'h2222);
		check(local_store_address_o, 9'h006);
		op(FN_LOAD_WRITE_INC, 9'h007, 16'h3333);
		check(local_store_address_o, 9'h008);
		op(FN_LOAD_WRITE, 9'h006, 16'h4444);
		op(FN_LOAD_READ, 9'h005);
		check(md_o, 16'h2222);
		op(FN_READ_INC);
		check(md_o, 16'h2222);
		check(local_store_address_o, 9'h006);
		op(FN_READ);
		check(md_o, 16'h4444);
		op(FN_INC_READ);
		check(md_o, 16'h3333);
		op(FN_LOAD_READ_ALT, 9'h006);
		check(md_o, 16'h4444);
		op(FN_SET_LOAD, 9'h005);
		check(md_o, 16'h2222);
		op(FN_SET_STORE, 9'h007);
		check(local_store_address_o, 9'h007);
	endtask
	task automatic t_pair();
		op(FN_LOAD_WRITE_TWO, 9'h020, 16'hAAAA, 16'hBBBB, , 3);
		op(FN_INC_WRITE_TWO, , 16'hCCCC, 16'hDDDD, , 3);
		check(local_store_address_o, 9'h023);
		op(FN_LOAD_READ_TWO, 9'h020, , , , 3);
		check({md_o, md2_o}, 32'hAAAABBBB);
		op(FN_INC_READ_TWO, , , , , 3);
		check({md_o, md2_o}, 32'hCCCCDDDD);
		check(local_store_address_o, 9'h023);
	endtask
	task automatic t_indirect();
		op(FN_WRITE_IND, 9'h1FF, 16'h5A5A, , 16'h0030);
		op(FN_READ_IND, 9'h1FF, 16'h0030);
		check(md_o, 16'h5A5A);
		op(FN_LOAD_READ, 9'h030);
		check(md_o, 16'h5A5A);
	endtask
	task automatic t_blocks();
		logic [4:0] codes [5] = '{FN_BLK_GR, FN_BLK_FP, FN_BLK_CSP, FN_BLK_WORK, FN_BLK_ALLCSP};
		int n [5] = '{8, 24, 12, 8, 16};
		int r0;
		r0 = lste_proc_model_i.re_n;
		op(FN_BLK_ASP, 9'h03F, .cyc(65), .poke(1));
		check(lste_proc_model_i.re_n - r0, 32);
		check(local_store_address_o, 9'h05F);
		op(FN_LOAD_READ, 9'h040);
		check(md_o, 16'hA400);
		op(FN_LOAD_READ, 9'h05F);
		check(md_o, 16'hA41F);
		r0 = lste_proc_model_i.we_n;
		op(FN_BLK_BSP | 5'h01, 9'h03F, .cyc(65));
		check(lste_proc_model_i.we_n - r0, 32);
		for (int i = 0; i < 32; i++) begin
			check(lste_proc_model_i.mem[SEL_BSP][i], 32'hA400 + i);
			if (i < 8) begin
				check(lste_proc_model_i.mem[SEL_BSP][i], lste_proc_model_i.mem[SEL_ASP][i]);
			end
		end
		for (int j = 0; j < 5; j++) begin
			r0 = lste_proc_model_i.re_n;
			op(codes[j], 9'h0FF, .cyc(2 * n[j] + 1));
			check(lste_proc_model_i.re_n - r0, n[j]);
		end
		check(lste_proc_model_i.const_bad, 0);
	endtask
	initial begin
		ep_load_i <= 1'b0;
		ep_code_i <= '0;
		d_reg_i <= '0;
		md_i <= '0;
		md2_i <= '0;
		work_reg_a0_i <= '0;
		repeat (10) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		t_reset();
		t_single();
		t_pair();
		t_indirect();
		t_blocks();
		report_and_stop();
	end
	// Whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		err_count++;
		report_and_stop();
	end
endmodule // tb_top
